//--- rsag_defs.svh
// Constants for the serial access guard of the real-time clock
`ifndef RSAG_DEFS_SVH
`define RSAG_DEFS_SVH

`define RSAG_MCLK_KHZ 200000
`define RSAG_TIMEOUT_MS 950
`define RSAG_TO_W 28
`define RSAG_BYTE_BITS 4'h8
`define RSAG_DEV_ADDR 7'h51
`define RSAG_CLK_REG_FIRST 8'h00
`define RSAG_CLK_REG_LAST 8'h0F
`define RSAG_FLAG_REG 8'h0E
`define RSAG_FLAG_BIT 1
`define RSAG_FIFO_DEPTH 16

`endif

//--- rsag_pkg.sv
// Types shared by the serial access guard
package rsag_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } rsag_word_t;

  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_AACK,
    S_PTR,
    S_PACK,
    S_WDAT,
    S_WACK,
    S_RDAT,
    S_RACK
  } rsag_state_t;

endpackage : rsag_pkg

//--- rsag_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module rsag_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_reg [D];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;
  logic full;
  logic empty;
  logic out_valid_reg;
  logic [W-1:0] out_data_reg;

  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = wr_ptr_reg == rd_ptr_reg;
  assign in_ready_o = !full;
  assign out_valid_o = out_valid_reg;
  assign push = in_valid_i && !full;
  // Head word sits in a register; it refills in the same cycle it is handed over
  assign pop = !empty && (!out_valid_reg || out_ready_i);
  assign out_data_o = out_data_reg;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (pop) begin
      out_data_reg <= mem_reg[rd_ptr_reg[AW-1:0]];
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_valid_reg <= 1'b0;
    end else if (pop) begin
      out_valid_reg <= 1'b1;
    end else if (out_ready_i) begin
      out_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    full && !pop |=> $stable(wr_ptr_reg)) else $error("fifo written while full");
  a_fifo_head_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o)) else $error("fifo head lost while stalled");

endmodule : rsag_fifo

//--- rsag_access_guard.sv
// Serial bus access guard: two-wire slave, bus timeout and byte-wise commit
// Operation
// - Device resets its bus interface once a transaction stays open 0.95 s.
// - A write byte cut short before its eighth bit is never stored.
// - Cut off outside acknowledge: bytes confirmed before acknowledge stay valid.
// - Cut off during acknowledge: only bytes of the last completed acknowledge stay valid.
// - Clock registers 00h to 0Fh only update while the oscillator runs.
// - Oscillation-loss flag reads 1 after power-on and after the clock setting is lost.
// - With the flag at 0, access is accepted at once without settle wait.
`timescale 1ns/1ps
`include "rsag_defs.svh"
module rsag_access_guard #(
  parameter int unsigned TIMEOUT_CYC = `RSAG_TIMEOUT_MS * `RSAG_MCLK_KHZ
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic osc_running_i,
  input wire logic supply_drop_i,
  output logic oscillation_loss_flag_o,
  output logic timeout_o,
  output logic wr_valid_o,
  output rsag_pkg::rsag_word_t wr_word_o,
  input wire logic wr_ready_i
);
  localparam logic [`RSAG_TO_W-1:0] TO_LAST = `RSAG_TO_W'(TIMEOUT_CYC - 1);
  localparam logic [`RSAG_TO_W-1:0] TO_DONE = `RSAG_TO_W'(TIMEOUT_CYC);

  // Link domain
  rsag_pkg::rsag_state_t state_reg;
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic to_s1_reg, to_s2_reg, to_d_reg;
  logic ack_s1_reg, ack_s2_reg;
  logic flag_s1_reg, flag_s2_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic [7:0] wbyte_reg;
  logic rw_reg;
  logic racked_reg;
  logic sda_oe_n_reg;
  logic scl_oe_n_reg;
  logic open_reg;
  logic hs_req_reg;
  rsag_pkg::rsag_word_t hs_word_reg;
  logic scl_rise, scl_fall, start_det, stop_det, to_evt, busy, byte_done, commit;

  // Main domain
  logic req_s1_reg, req_s2_reg, req_seen_reg;
  logic open_s1_reg, open_s2_reg;
  logic osc_s1_reg, osc_s2_reg;
  logic drop_s1_reg, drop_s2_reg;
  logic [`RSAG_TO_W-1:0] to_cnt_reg;
  logic to_tgl_reg;
  logic timeout_reg;
  logic flag_reg;
  logic wr_valid_reg;
  rsag_pkg::rsag_word_t wr_word_reg;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready, push, drain_ok, take;
  logic [15:0] fifo_out_data;
  rsag_pkg::rsag_word_t fifo_word;

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n_o = scl_oe_n_reg;
  assign sda_oe_n_o = sda_oe_n_reg;
  assign oscillation_loss_flag_o = flag_reg;
  assign timeout_o = timeout_reg;
  assign wr_valid_o = wr_valid_reg;
  assign wr_word_o = wr_word_reg;

  // ---------------- Link domain ----------------
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_s1_reg <= scl_i;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
    end
  end

  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      to_s1_reg <= 1'b0;
      to_s2_reg <= 1'b0;
      to_d_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      flag_s1_reg <= 1'b1;
      flag_s2_reg <= 1'b1;
    end else begin
      to_s1_reg <= to_tgl_reg;
      to_s2_reg <= to_s1_reg;
      to_d_reg <= to_s2_reg;
      ack_s1_reg <= req_seen_reg;
      ack_s2_reg <= ack_s1_reg;
      flag_s1_reg <= flag_reg;
      flag_s2_reg <= flag_s1_reg;
    end
  end

  assign scl_rise = scl_s2_reg && !scl_d_reg;
  assign scl_fall = !scl_s2_reg && scl_d_reg;
  assign start_det = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  assign stop_det = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;
  assign to_evt = to_s2_reg ^ to_d_reg;
  assign busy = hs_req_reg != ack_s2_reg;
  // Counted after the eighth rising edge, so a byte cut short never reaches this
  assign byte_done = (bit_cnt_reg == `RSAG_BYTE_BITS) && !scl_s2_reg;
  assign commit = (state_reg == rsag_pkg::S_WACK) && scl_fall && !to_evt && !start_det && !stop_det;

  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= rsag_pkg::S_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      wbyte_reg <= 8'h00;
      rw_reg <= 1'b0;
      racked_reg <= 1'b0;
      sda_oe_n_reg <= 1'b1;
      scl_oe_n_reg <= 1'b1;
    end else if (to_evt) begin
      state_reg <= rsag_pkg::S_IDLE;
      sda_oe_n_reg <= 1'b1;
      scl_oe_n_reg <= 1'b1;
    end else if (start_det) begin
      // Access is taken straight away, whatever the oscillation-loss flag says
      state_reg <= rsag_pkg::S_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_n_reg <= 1'b1;
      scl_oe_n_reg <= 1'b1;
    end else if (stop_det) begin
      state_reg <= rsag_pkg::S_IDLE;
      sda_oe_n_reg <= 1'b1;
      scl_oe_n_reg <= 1'b1;
    end else begin
      if (scl_rise && bit_cnt_reg != `RSAG_BYTE_BITS) begin
        shift_reg <= {shift_reg[6:0], sda_s2_reg};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      unique case (state_reg)
        rsag_pkg::S_IDLE: begin
          sda_oe_n_reg <= 1'b1;
        end
        rsag_pkg::S_ADDR: begin
          if (byte_done) begin
            if (shift_reg[7:1] == `RSAG_DEV_ADDR) begin
              state_reg <= rsag_pkg::S_AACK;
              rw_reg <= shift_reg[0];
              sda_oe_n_reg <= 1'b0;
            end else begin
              state_reg <= rsag_pkg::S_IDLE;
            end
          end
        end
        rsag_pkg::S_AACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              tx_reg <= {6'h00, flag_s2_reg, 1'b0};
              sda_oe_n_reg <= 1'b1;
              state_reg <= rsag_pkg::S_RDAT;
            end else begin
              sda_oe_n_reg <= 1'b1;
              state_reg <= rsag_pkg::S_PTR;
            end
          end
        end
        rsag_pkg::S_PTR: begin
          if (byte_done) begin
            ptr_reg <= shift_reg;
            sda_oe_n_reg <= 1'b0;
            state_reg <= rsag_pkg::S_PACK;
          end
        end
        rsag_pkg::S_PACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            sda_oe_n_reg <= 1'b1;
            state_reg <= rsag_pkg::S_WDAT;
          end
        end
        rsag_pkg::S_WDAT: begin
          if (byte_done) begin
            // Clock stretching is the back-pressure from the FIFO onto the master
            if (busy) begin
              scl_oe_n_reg <= 1'b0;
            end else begin
              // Clock is let go one cycle after the acknowledge, so data never moves with a rising clock
              wbyte_reg <= shift_reg;
              sda_oe_n_reg <= 1'b0;
              state_reg <= rsag_pkg::S_WACK;
            end
          end
        end
        rsag_pkg::S_WACK: begin
          scl_oe_n_reg <= 1'b1;
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            ptr_reg <= ptr_reg + 8'h01;
            sda_oe_n_reg <= 1'b1;
            state_reg <= rsag_pkg::S_WDAT;
          end
        end
        rsag_pkg::S_RDAT: begin
          if (byte_done) begin
            sda_oe_n_reg <= 1'b1;
            state_reg <= rsag_pkg::S_RACK;
          end else if (scl_fall || (bit_cnt_reg == 4'h0 && !scl_s2_reg)) begin
            sda_oe_n_reg <= tx_reg[3'(7 - bit_cnt_reg)];
          end
        end
        rsag_pkg::S_RACK: begin
          if (scl_rise) begin
            racked_reg <= !sda_s2_reg;
          end
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= racked_reg ? rsag_pkg::S_RDAT : rsag_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // A byte becomes valid only when its acknowledge clock has completed
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hs_req_reg <= 1'b0;
      hs_word_reg <= '0;
    end else if (commit) begin
      hs_req_reg <= !hs_req_reg;
      hs_word_reg <= '{addr: ptr_reg, data: wbyte_reg};
    end
  end

  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      open_reg <= 1'b0;
    end else begin
      open_reg <= state_reg != rsag_pkg::S_IDLE;
    end
  end

  // ---------------- Main domain ----------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      open_s1_reg <= 1'b0;
      open_s2_reg <= 1'b0;
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      drop_s1_reg <= 1'b0;
      drop_s2_reg <= 1'b0;
    end else begin
      req_s1_reg <= hs_req_reg;
      req_s2_reg <= req_s1_reg;
      open_s1_reg <= open_reg;
      open_s2_reg <= open_s1_reg;
      osc_s1_reg <= osc_running_i;
      osc_s2_reg <= osc_s1_reg;
      drop_s1_reg <= supply_drop_i;
      drop_s2_reg <= drop_s1_reg;
    end
  end

  // Bus timeout: counts while a transaction is open, fires once, holds until it closes
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      to_cnt_reg <= '0;
      to_tgl_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= 1'b0;
      if (!open_s2_reg) begin
        to_cnt_reg <= '0;
      end else if (to_cnt_reg == TO_LAST) begin
        to_cnt_reg <= TO_DONE;
        to_tgl_reg <= !to_tgl_reg;
        timeout_reg <= 1'b1;
      end else if (to_cnt_reg != TO_DONE) begin
        to_cnt_reg <= to_cnt_reg + 1'b1;
      end
    end
  end

  assign push = req_s2_reg != req_seen_reg;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_seen_reg <= 1'b0;
    end else if (push && fifo_in_ready) begin
      req_seen_reg <= req_s2_reg;
    end
  end

  rsag_fifo #(
    .W($bits(rsag_pkg::rsag_word_t)),
    .D(`RSAG_FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(hs_word_reg),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  assign fifo_word = rsag_pkg::rsag_word_t'(fifo_out_data);
  // Clock registers stall while the oscillator is stopped; the FIFO absorbs the wait
  assign drain_ok = osc_s2_reg || (fifo_word.addr > `RSAG_CLK_REG_LAST);
  assign fifo_out_ready = drain_ok && (!wr_valid_reg || wr_ready_i);
  assign take = fifo_out_valid && fifo_out_ready;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_valid_reg <= 1'b0;
      wr_word_reg <= '0;
    end else if (take) begin
      wr_valid_reg <= 1'b1;
      wr_word_reg <= fifo_word;
    end else if (wr_ready_i) begin
      wr_valid_reg <= 1'b0;
    end
  end

  // Loss set wins over a software clear in the same cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_reg <= 1'b1;
    end else if (drop_s2_reg || !osc_s2_reg) begin
      flag_reg <= 1'b1;
    end else if (take && fifo_word.addr == `RSAG_FLAG_REG && !fifo_word.data[`RSAG_FLAG_BIT]) begin
      flag_reg <= 1'b0;
    end
  end

  // ---------------- Checks ----------------
  sequence ack_clock_done;
    (state_reg == rsag_pkg::S_WACK) && scl_fall && !to_evt && !start_det && !stop_det;
  endsequence

  sequence ack_cut_off;
    (state_reg == rsag_pkg::S_WACK) && (start_det || stop_det || to_evt);
  endsequence

  a_timeout_fires: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    open_s2_reg && to_cnt_reg == TO_LAST |=> timeout_reg && $changed(to_tgl_reg)) else $error("timeout missed");
  a_timeout_idle: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    to_evt |=> state_reg == rsag_pkg::S_IDLE && sda_oe_n_o && scl_oe_n_o) else $error("bus not idle after timeout");
  a_commit_after_ack: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    $changed(hs_req_reg) |-> $past(state_reg) == rsag_pkg::S_WACK && $past(scl_fall)) else $error("commit off ack");
  a_ack_commit_word: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    ack_clock_done |=> $changed(hs_req_reg) && hs_word_reg.data == $past(wbyte_reg)) else $error("byte not committed");
  a_ack_cut_drop: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    ack_cut_off |=> $stable(hs_req_reg)) else $error("byte kept despite cut ack");
  a_partial_byte: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    state_reg == rsag_pkg::S_WDAT && bit_cnt_reg < `RSAG_BYTE_BITS |=> $stable(wbyte_reg) && $stable(hs_req_reg))
    else $error("partial byte stored");
  a_clock_reg_gate: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    take && fifo_word.addr <= `RSAG_CLK_REG_LAST |-> osc_s2_reg ##1 wr_valid_o) else $error("clock write without osc");
  a_flag_on_loss: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    drop_s2_reg |=> oscillation_loss_flag_o [*2]) else $error("loss flag not set");
  a_start_taken: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    start_det && !to_evt |=> state_reg == rsag_pkg::S_ADDR ##0 bit_cnt_reg == 4'h0) else $error("start not taken");

endmodule : rsag_access_guard

//--- rsag_bus_master.sv
// Behavioural two-wire bus master standing on the far side of the access guard
`timescale 1ns/1ps
module rsag_bus_master #(
  parameter int HALF = 60
) (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Bit time keeps every access far inside the bus timeout
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task start;
    sda_o = 1'b1;
    scl_o = 1'b1;
    #HALF sda_o = 1'b0;
    #HALF scl_o = 1'b0;
  endtask : start
  task stop;
    #(HALF/2) sda_o = 1'b0;
    #(HALF/2) scl_o = 1'b1;
    #HALF sda_o = 1'b1;
    #HALF;
  endtask : stop
  // Data moves only while the clock is low, so no false start or stop is seen
  task clk_bit(input logic b, output logic r);
    #(HALF/2) sda_o = b;
    #(HALF/2) scl_o = 1'b1;
    wait (scl_i === 1'b1);
    #(HALF/2) r = sda_i;
    #(HALF/2) scl_o = 1'b0;
  endtask : clk_bit
  // Whole bytes only, never paused inside one
  task wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
    end
    clk_bit(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  task rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(nack, r);
  endtask : rd_byte
  // Raises the acknowledge clock and leaves it high, stalling the access
  task ack_hold;
    #(HALF/2) sda_o = 1'b1;
    #(HALF/2) scl_o = 1'b1;
  endtask : ack_hold
  task scl_fall;
    #(HALF/2) scl_o = 1'b0;
  endtask : scl_fall
endmodule : rsag_bus_master

//--- rsag_access_guard_tb.sv
// Self-checking bench for the serial access guard
`timescale 1ns/1ps
`include "rsag_defs.svh"
module rsag_access_guard_tb;
  // Short timeout keeps the run brief; all timing checks derive from it
  localparam int TO = 2000;
  localparam logic [7:0] AW = {`RSAG_DEV_ADDR, 1'b0};
  localparam logic [7:0] AR = {`RSAG_DEV_ADDR, 1'b1};
  logic mclk, link_clk, reset_n, osc, drop, rdy;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, flag, tmo, wr_valid, m_scl, m_sda;
  wire logic scl_w, sda_w;
  rsag_pkg::rsag_word_t wr_word;
  logic [15:0] got[$];
  int cmp_count = 0;
  int n_mismatch = 0;
  int n_to = 0;
  int cyc = 0;

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  // Pull-ups on both wires: a released line reads high
  assign scl_w = m_scl & (scl_oe_n | scl_o);
  assign sda_w = m_sda & (sda_oe_n | sda_o);

  rsag_access_guard #(.TIMEOUT_CYC(TO)) dut (.mclk_i(mclk), .reset_n_i(reset_n), .link_clk_i(link_clk),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .osc_running_i(osc), .supply_drop_i(drop), .oscillation_loss_flag_o(flag),
    .timeout_o(tmo), .wr_valid_o(wr_valid), .wr_word_o(wr_word), .wr_ready_i(rdy));
  rsag_bus_master #(.HALF(60)) m (.scl_i(scl_w), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));

  always @(posedge mclk) begin
    cyc++;
    if (wr_valid === 1'b1 && rdy === 1'b1) got.push_back(wr_word);
    if (tmo === 1'b1) n_to++;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic take(input logic [15:0] exp);
    logic [15:0] w;
    w = 'x;
    for (int i = 0; i < 400 && got.size() == 0; i++) tick(1);
    if (got.size() > 0) w = got.pop_front();
    check("committed word", w, exp);
  endtask : take
  task automatic none_left;
    check("words left", 16'(got.size()), 16'h0000);
  endtask : none_left
  task automatic wr_txn(input logic [7:0] ptr, input logic [15:0] data, input int n);
    logic ack;
    m.start();
    m.wr_byte(AW, ack);
    check("address ack", 16'(ack), 16'h1);
    m.wr_byte(ptr, ack);
    check("pointer ack", 16'(ack), 16'h1);
    for (int i = 0; i < n; i++) begin
      m.wr_byte(data[15-8*i -: 8], ack);
      check("data ack", 16'(ack), 16'h1);
    end
    m.stop();
  endtask : wr_txn
  task automatic rd_status(input logic [7:0] exp);
    logic ack;
    logic [7:0] d;
    m.start();
    m.wr_byte(AR, ack);
    m.rd_byte(1'b1, d);
    m.stop();
    check("status ack", 16'(ack), 16'h1);
    check("status byte", 16'(d), 16'(exp));
  endtask : rd_status

  task automatic t_reset;
    check("flag after reset", 16'(flag), 16'h1);
    check("sda idle", 16'(sda_oe_n), 16'h1);
    check("scl idle", 16'(scl_oe_n), 16'h1);
    check("timeout idle", 16'(tmo), 16'h0);
  endtask : t_reset
  task automatic t_flag;
    rd_status(8'h02); // Status read comes first
    tick(50); // Settle time before initialising
    wr_txn(`RSAG_FLAG_REG, 16'h0000, 1);
    take({`RSAG_FLAG_REG, 8'h00});
    tick(20);
    check("flag cleared", 16'(flag), 16'h0);
    rd_status(8'h00);
    drop = 1'b1;
    tick(10);
    check("flag on drop", 16'(flag), 16'h1);
    drop = 1'b0;
    tick(10);
    check("flag sticks", 16'(flag), 16'h1);
    rd_status(8'h02);
  endtask : t_flag
  task automatic t_backpressure;
    rdy = 1'b0;
    fork
      wr_txn(8'h20, 16'hA53C, 2);
      begin
        for (int i = 0; i < 2000 && wr_valid !== 1'b1; i++) tick(1);
        tick(30);
        check("valid held", 16'(wr_valid), 16'h1);
        check("word held", wr_word, 16'h20A5);
        rdy = 1'b1;
      end
    join
    take(16'h20A5);
    take(16'h213C);
    tick(50);
    none_left();
  endtask : t_backpressure
  task automatic t_clock_gate;
    osc = 1'b0;
    tick(10);
    wr_txn(8'h05, 16'h1100, 1);
    tick(100);
    none_left(); // Held back while the oscillator is stopped
    osc = 1'b1;
    take(16'h0511);
  endtask : t_clock_gate
  task automatic t_partial;
    logic ack;
    logic r;
    m.start();
    m.wr_byte(AW, ack);
    m.wr_byte(8'h30, ack);
    // Seven bits is the longest byte that is still incomplete
    for (int i = 0; i < 7; i++) m.clk_bit(i[0], r);
    m.stop();
    tick(100);
    none_left();
  endtask : t_partial
  task automatic t_timeout;
    int t0;
    int el;
    logic ack;
    logic r;
    t0 = cyc;
    m.start();
    m.wr_byte(AW, ack);
    m.wr_byte(8'h40, ack);
    m.wr_byte(8'h77, ack);
    for (int i = 7; i >= 0; i--) m.clk_bit(i[0], r);
    m.ack_hold();
    tick(4);
    check("ack during hold", 16'(sda_oe_n), 16'h0);
    for (int i = 0; i < TO + 400 && tmo !== 1'b1; i++) tick(1);
    el = cyc - t0;
    // Start lands 12 cycles in; syncing adds a little more
    check("timeout delay", 16'(el >= TO + 12 && el <= TO + 40), 16'h1);
    tick(20);
    check("sda released", 16'(sda_oe_n), 16'h1);
    take(16'h4077);
    tick(50);
    none_left(); // Byte cut during its acknowledge is lost
    m.scl_fall();
    m.wr_byte(AW, ack);
    check("ignored without start", 16'(ack), 16'h0);
    m.stop();
    wr_txn(8'h50, 16'h5A00, 1);
    take(16'h505A);
    check("timeout count", 16'(n_to), 16'h1);
  endtask : t_timeout
  // Twenty bytes to registers 00h to 13h with the oscillator stopped overflow the buffer and force clock stretching
  task automatic t_stretch;
    logic ack;
    osc = 1'b0;
    fork
      for (int t = 0; t < 4; t++) begin
        m.start();
        m.wr_byte(AW, ack);
        m.wr_byte(8'(5 * t), ack);
        for (int i = 0; i < 5; i++) m.wr_byte(8'(5 * t + i), ack);
        m.stop();
      end
      begin
        for (int i = 0; i < 8000 && scl_oe_n !== 1'b0; i++) tick(1);
        check("scl stretched", 16'(scl_oe_n), 16'h0);
        check("nothing drained", 16'(wr_valid), 16'h0);
        osc = 1'b1;
      end
    join
    for (int k = 0; k < 20; k++) take({8'(k), 8'(k)});
    none_left();
    check("no timeout while stretched", 16'(n_to), 16'h1);
  endtask : t_stretch

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  initial begin
    reset_n = 1'b0;
    osc = 1'b1;
    drop = 1'b0;
    rdy = 1'b1;
    repeat (2) @(posedge link_clk);
    tick(1);
    reset_n = 1'b1;
    tick(3);
    t_reset();
    t_flag();
    t_backpressure();
    t_clock_gate();
    t_partial();
    t_timeout();
    t_stretch();
    test_done();
  end
  // The whole sequence needs under 100 us
  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end
endmodule : rsag_access_guard_tb
